// *** bench/bus_signal_if_monitor.sv ***
// port checker for the bus signal interface
`timescale 1ns/100ps
`include "bus_signal_if_defines.vh"
module bus_signal_if_monitor
(
    input wire        I_SYS_CLK,
    input wire        I_RST,
    input wire        I_PSEL,
    input wire        I_PENABLE,
    input wire        I_PWRITE,
    input wire [7:0]  I_PADDR,
    input wire [31:0] I_PWDATA,
    input wire        O_PREADY,
    input wire        I_BUS_REQ_N,
    input wire        I_CONTINUOUS_WAIT_N,
    input wire        I_RESET_IN_N,
    input wire        O_ADDR_STROBE_N,
    input wire        O_ADDR_STROBE_OE_N,
    input wire        O_BUS_GRANT_ACK_N,
    input wire        O_ADDR_LATCH_EN,
    input wire [3:0]  O_CYCLE_STATUS,
    input wire        O_STATE_TIMING_N,
    input wire        O_USER_MODE,
    input wire        O_INSTR_START_PULSE_N,
    input wire        O_BLIT_CYCLE_N,
    input wire        O_RESET_OUT_N
);
// ----------------------------------------------------------------
// properties on the system clock
// ----------------------------------------------------------------
default clocking cb @(posedge I_SYS_CLK);
endclocking
default disable iff (I_RST);
// control write taken at this edge
wire ctrl_wr = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE & (I_PADDR == `OFS_CTRL);
property p_ready; I_PSEL && !I_PENABLE |=> O_PREADY; endproperty
a_ready: assert property (p_ready) else $error("no ready after setup");
property p_rst_out; !I_RESET_IN_N |=> !O_RESET_OUT_N; endproperty
a_rst_out: assert property (p_rst_out) else $error("reset output high");
property p_grant; $fell(I_BUS_REQ_N) |-> ##[1:24] !O_BUS_GRANT_ACK_N; endproperty
a_grant: assert property (p_grant) else $error("bus not granted");
property p_back; $rose(O_BUS_GRANT_ACK_N) |-> $past(I_BUS_REQ_N); endproperty
a_back: assert property (p_back) else $error("grant dropped early");
property p_held;
    !O_BUS_GRANT_ACK_N |-> O_ADDR_LATCH_EN && O_ADDR_STROBE_OE_N && O_CYCLE_STATUS == 4'h0;
endproperty
a_held: assert property (p_held) else $error("pins wrong in grant");
property p_t2; $fell(O_ADDR_STROBE_N) |-> ##2 O_ADDR_STROBE_N && !O_STATE_TIMING_N; endproperty
a_t2: assert property (p_t2) else $error("timing not low in T2");
property p_wait;
    (!O_STATE_TIMING_N && !O_ADDR_STROBE_OE_N && !I_CONTINUOUS_WAIT_N) [*3] |=> !O_STATE_TIMING_N;
endproperty
a_wait: assert property (p_wait) else $error("wait state not held");
property p_blit; !O_BLIT_CYCLE_N |-> O_CYCLE_STATUS inside {4'h8, 4'h9, 4'hA}; endproperty
a_blit: assert property (p_blit) else $error("blit on wrong cycle");
property p_user; ctrl_wr |-> ##2 O_USER_MODE == $past(I_PWDATA[0], 2); endproperty
a_user: assert property (p_user) else $error("mode output wrong");
property p_pulse; $fell(O_INSTR_START_PULSE_N) |=> O_INSTR_START_PULSE_N; endproperty
a_pulse: assert property (p_pulse) else $error("start pulse too long");
c_grant: cover property (!O_BUS_GRANT_ACK_N);
c_wait: cover property (!O_STATE_TIMING_N && !I_CONTINUOUS_WAIT_N);
c_blit: cover property (!O_BLIT_CYCLE_N);
endmodule // bus_signal_if_monitor
bind bus_signal_if bus_signal_if_monitor u_mon
(
    .I_SYS_CLK, .I_RST, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR, .I_PWDATA, .O_PREADY,
    .I_BUS_REQ_N, .I_CONTINUOUS_WAIT_N, .I_RESET_IN_N, .O_ADDR_STROBE_N, .O_ADDR_STROBE_OE_N,
    .O_BUS_GRANT_ACK_N, .O_ADDR_LATCH_EN, .O_CYCLE_STATUS, .O_STATE_TIMING_N, .O_USER_MODE,
    .O_INSTR_START_PULSE_N, .O_BLIT_CYCLE_N, .O_RESET_OUT_N
);

// *** bench/bus_signal_if_test.sv ***
// self-checking testbench for the bus signal interface
`timescale 1ns/100ps
`include "bus_signal_if_defines.vh"
module bus_signal_if_test;
reg         clk, rst, psel, penable, pwrite, continuous_wait_n_n, int_n, nmi_n, rin_n, rerr, rs, ws, f;
reg  [7:0]  paddr;
reg  [31:0] pwdata, rdat;
wire [31:0] prdata;
wire [3:0]  stat;
wire        pready, pslverr, ads_o, ads_oe, dir_o, dir_oe, gnt_n, ale, tso_n, rd_n, wr_n;
wire        user, ilo_n, pfs_n, blit_n, reset_out_n_n, fast_clock_out, irq, req_n, m_ads, m_en, m_dir, dbe, bclk;
integer     n_fail, tests_run, cycles, k, lat;
// strobe line has a pull-up; direction follows whoever drives it
wire ads_w = !ads_oe ? ads_o : (m_en ? m_ads : 1'b1);
wire dir_w = !dir_oe ? dir_o : m_dir;
bus_signal_if u_dut
(
    .I_SYS_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_BUS_REQ_N(req_n), .I_INT_N(int_n), .I_NMI_N(nmi_n),
    .I_CONTINUOUS_WAIT_N(continuous_wait_n_n), .I_RESET_IN_N(rin_n), .I_ADDR_STROBE_N(ads_w),
    .O_ADDR_STROBE_N(ads_o), .O_ADDR_STROBE_OE_N(ads_oe), .I_TRANSFER_DIRECTION(dir_w),
    .O_TRANSFER_DIRECTION(dir_o), .O_TRANSFER_DIRECTION_OE_N(dir_oe),
    .O_BUS_GRANT_ACK_N(gnt_n), .O_ADDR_LATCH_EN(ale), .O_CYCLE_STATUS(stat),
    .O_STATE_TIMING_N(tso_n), .O_READ_N(rd_n), .O_WRITE_N(wr_n), .O_DATA_BUFFER_ENABLE(dbe),
    .O_USER_MODE(user), .O_INTERLOCK_ACTIVE_N(ilo_n), .O_INSTR_START_PULSE_N(pfs_n),
    .O_BLIT_CYCLE_N(blit_n), .O_RESET_OUT_N(reset_out_n_n), .O_BUS_CLOCK_OUT(bclk),
    .O_FAST_CLOCK_OUT(fast_clock_out), .O_CMDLIST_IRQ_OUT(irq)
);
dma_master_model u_dma
(
    .i_clk(clk), .i_grant_n(gnt_n), .i_rd_n(rd_n), .i_wr_n(wr_n),
    .o_req_n(req_n), .o_ads_n(m_ads), .o_ads_en(m_en), .o_dir(m_dir)
);
// ----------------------------------------------------------------
// clock, timeout and shared tasks
// ----------------------------------------------------------------
initial
begin
    clk = 1'b0;
    forever #25 clk = ~clk;
end
// the whole run needs well under a thousand clocks; a hang stops at the 20000-clock limit
always @(posedge clk)
begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
        n_fail = n_fail + 1;
        report_and_stop;
    end
end
task report_and_stop;
begin
    if (n_fail == 0 && tests_run > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
end
endtask
task check(input logic [31:0] got, input logic [31:0] exp);
begin
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
        n_fail = n_fail + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
end
endtask
task tk(input integer n);
    repeat (n) @(posedge clk);
endtask
// one APB transfer; read data and error taken at the edge that sees ready
task apb(input reg wr, input reg [7:0] a, input reg [31:0] wd);
begin
    k = 0;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
        @(posedge clk);
        k = k + 1;
    end
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
end
endtask
// bounded wait until the strobe (0) or timing output (1) shows a level
task wait_on(input integer w, input reg lvl);
begin
    k = 0;
    while ((w ? tso_n : ads_o) !== lvl && k < 40)
    begin
        @(posedge clk);
        k = k + 1;
    end
end
endtask
// ----------------------------------------------------------------
// scenarios
// ----------------------------------------------------------------
task s_codes;
integer c;
begin
    for (c = 0; c < 16; c = c + 1)
    begin
        apb(1'b1, `OFS_CMD, {24'h0, 3'h4, c[0], c[3:0]});
        wait_on(0, 1'b0);
        check(stat, c[3:0]);
        wait_on(1, 1'b0);
        check({rd_n, wr_n}, {c[0], ~c[0]});
        check({dbe, dir_o}, {1'b1, c[0]});
        check(blit_n, c[3:1] != 3'h4);
        wait_on(1, 1'b1);
        tk(4);
    end
end
endtask
task s_wait;
begin
    apb(1'b1, `OFS_CMD, 32'h0000_009A);
    wait_on(0, 1'b0);
    continuous_wait_n_n <= 1'b0;
    tk(12);
    check(tso_n, 1'b0);
    continuous_wait_n_n <= 1'b1;
    wait_on(1, 1'b1);
    check(k < 6, 1'b1);
end
endtask
task s_hold;
begin
    u_dma.grab(lat);
    check(lat <= 6, 1'b1);
    check({ale, ads_oe, dir_oe, stat}, 7'h70);
    u_dma.xfer(1'b0, rs, ws);
    check({rs, ws}, 2'b10);
    u_dma.xfer(1'b1, rs, ws);
    check({rs, ws}, 2'b01);
    u_dma.release_bus(lat);
    check(gnt_n, 1'b1);
    apb(1'b1, `OFS_CMD, 32'h0000_0088);
    wait_on(0, 1'b0);
    u_dma.grab(lat);
    check(lat >= 4 && lat <= 12, 1'b1);
    u_dma.release_bus(lat);
end
endtask
task s_irq;
begin
    int_n <= 1'b0;
    tk(4);
    apb(1'b0, `OFS_STATUS, 32'h0);
    check(rdat[2:1], 2'b01);
    nmi_n <= 1'b0;
    tk(4);
    apb(1'b0, `OFS_STATUS, 32'h0);
    check(rdat[2], 1'b1);
    apb(1'b1, `OFS_CLEAR, 32'h1);
    apb(1'b0, `OFS_STATUS, 32'h0);
    check(rdat[2], 1'b0);
    int_n <= 1'b1;
    nmi_n <= 1'b1;
    tk(4);
    apb(1'b0, `OFS_STATUS, 32'h0);
    check(rdat[2:1], 2'b00);
end
endtask
task s_regs;
begin
    apb(1'b1, `OFS_CTRL, 32'h0000_002D);
    apb(1'b0, `OFS_CTRL, 32'h0);
    check(rdat, 32'h0000_002D);
    check({user, ilo_n}, 2'b10);
    f = fast_clock_out;
    for (k = 0; k < 20 && fast_clock_out === f; k = k + 1) @(posedge clk);
    f = fast_clock_out;
    for (k = 0; k < 20 && fast_clock_out === f; k = k + 1) @(posedge clk);
    check(k, 4);
    f = bclk;
    tk(1);
    check(bclk, !f);
    apb(1'b1, `OFS_CMD, 32'h0000_0060);
    k = 0;
    for (lat = 0; lat < 6; lat = lat + 1)
    begin
        @(posedge clk);
        k = k + (pfs_n === 1'b0);
    end
    check(k, 1);
    check(irq, 1'b1);
    apb(1'b1, `OFS_CLEAR, 32'h2);
    apb(1'b1, `OFS_CTRL, 32'h0);
    apb(1'b1, `OFS_CMD, 32'h0000_0040);
    tk(3);
    check(irq, 1'b0);
    apb(1'b0, 8'h10, 32'h0);
    check(rerr, 1'b1);
    check(rdat, 32'h0);
    apb(1'b1, `OFS_CTRL, 32'h0000_0010);
    apb(1'b1, `OFS_CMD, 32'h0000_008A);
    wait_on(0, 1'b0);
    check(blit_n, 1'b0);
end
endtask
task s_rst_out;
begin
    rin_n <= 1'b0;
    tk(3);
    check(reset_out_n_n, 1'b0);
    rin_n <= 1'b1;
    tk(3);
    check(reset_out_n_n, 1'b1);
end
endtask
initial
begin
    {n_fail, tests_run, cycles} = 0;
    {rst, continuous_wait_n_n, int_n, nmi_n, rin_n} = 5'h1F;
    {psel, penable, pwrite, paddr, pwdata} = 0;
    tk(6);
    rst <= 1'b0;
    s_codes;
    s_wait;
    s_hold;
    s_irq;
    s_regs;
    s_rst_out;
    report_and_stop;
end
endmodule // bus_signal_if_test

// *** bench/dma_master_model.sv ***
// far-side bus master that borrows the bus through the hold handshake
`timescale 1ns/100ps
module dma_master_model
(
    input  wire i_clk,
    input  wire i_grant_n,
    input  wire i_rd_n,
    input  wire i_wr_n,
    output reg  o_req_n,
    output reg  o_ads_n,
    output reg  o_ads_en,
    output reg  o_dir
);
// ----------------------------------------------------------------
// handshake tasks
// ----------------------------------------------------------------
initial
begin
    o_req_n  = 1'b1;
    o_ads_n  = 1'b1;
    o_ads_en = 1'b0;
    o_dir    = 1'b0;
end
// request launched just after an edge, so it is already in step with the system clock
task grab(output integer lat);
begin
    lat = 0;
    @(posedge i_clk);
    o_req_n <= 1'b0;
    while (i_grant_n !== 1'b0 && lat < 40)
    begin
        @(posedge i_clk);
        lat = lat + 1;
    end
    o_ads_en <= 1'b1;
end
endtask
// one transfer: strobe low two clocks so a bus tick is sure to see it
task xfer(input reg wr, output reg rd_seen, output reg wr_seen);
integer n;
begin
    rd_seen = 1'b0;
    wr_seen = 1'b0;
    @(posedge i_clk);
    o_ads_n <= 1'b0;
    o_dir   <= wr;
    for (n = 0; n < 8; n = n + 1)
    begin
        @(posedge i_clk);
        if (n == 1)
            o_ads_n <= 1'b1;
        rd_seen = rd_seen | ~i_rd_n;
        wr_seen = wr_seen | ~i_wr_n;
    end
end
endtask
// hand the bus back; the released direction line no longer shows its old level
task release_bus(output integer lat);
begin
    lat = 0;
    o_ads_en <= 1'b0;
    o_req_n  <= 1'b1;
    while (i_grant_n !== 1'b1 && lat < 40)
    begin
        @(posedge i_clk);
        lat = lat + 1;
    end
    o_dir <= ~o_dir;
end
endtask
endmodule // dma_master_model

// *** design/bus_signal_if.v ***
// external bus signal interface: cycle sequencer, hold arbitration, strobes
`timescale 1ns/100ps
`include "bus_signal_if_defines.vh"
module bus_signal_if
(
    input  wire        I_SYS_CLK,
    input  wire        I_RST,
    input  wire        I_PSEL,
    input  wire        I_PENABLE,
    input  wire        I_PWRITE,
    input  wire [7:0]  I_PADDR,
    input  wire [31:0] I_PWDATA,
    output reg  [31:0] O_PRDATA,
    output reg         O_PREADY,
    output reg         O_PSLVERR,
    input  wire        I_BUS_REQ_N,
    input  wire        I_INT_N,
    input  wire        I_NMI_N,
    input  wire        I_CONTINUOUS_WAIT_N,
    input  wire        I_RESET_IN_N,
    input  wire        I_ADDR_STROBE_N,
    output reg         O_ADDR_STROBE_N,
    output reg         O_ADDR_STROBE_OE_N,
    input  wire        I_TRANSFER_DIRECTION,
    output reg         O_TRANSFER_DIRECTION,
    output reg         O_TRANSFER_DIRECTION_OE_N,
    output reg         O_BUS_GRANT_ACK_N,
    output reg         O_ADDR_LATCH_EN,
    output reg  [3:0]  O_CYCLE_STATUS,
    output reg         O_STATE_TIMING_N,
    output reg         O_READ_N,
    output reg         O_WRITE_N,
    output reg         O_DATA_BUFFER_ENABLE,
    output reg         O_USER_MODE,
    output reg         O_INTERLOCK_ACTIVE_N,
    output reg         O_INSTR_START_PULSE_N,
    output reg         O_BLIT_CYCLE_N,
    output reg         O_RESET_OUT_N,
    output reg         O_BUS_CLOCK_OUT,
    output reg         O_FAST_CLOCK_OUT,
    output reg         O_CMDLIST_IRQ_OUT
);
    // states (one-hot)
    localparam [5:0] S_IDLE = 6'h01;
    localparam [5:0] S_T1   = 6'h02;
    localparam [5:0] S_T2   = 6'h04;
    localparam [5:0] S_T3   = 6'h08;
    localparam [5:0] S_T4   = 6'h10;
    localparam [5:0] S_HOLD = 6'h20;
    // prefetch codes enable the external blitter
    function is_fetch;
        input [3:0] code;
        begin
            is_fetch = (code == `ST_FETCH_SEQ) || (code == `ST_FETCH_NSEQ);
        end
    endfunction
    reg [5:0]  state_q;
    reg [5:0]  state_d;
    reg [`CTRL_WIDTH-1:0] ctrl_q;
    reg        hold_req_q;
    reg        int_s1_q;
    reg        int_s2_q;
    reg        nmi_s1_q;
    reg        nmi_s2_q;
    reg        nmi_s3_q;
    reg        nmi_pend_q;
    reg        irq_q;
    reg        cmd_pend_q;
    reg [3:0]  cmd_code_q;
    reg        cmd_write_q;
    reg        committed_q;
    reg [3:0]  cyc_code_q;
    reg        cyc_write_q;
    reg        bclk_q;
    reg [3:0]  fdiv_q;
    reg        dma_ads_q;
    reg [1:0]  dma_cnt_q;
    reg        dma_write_q;
    wire       tick      = ~bclk_q;   // bus clock rises on the next edge
    wire       apb_acc   = I_PSEL & I_PENABLE & O_PREADY;
    wire       apb_wr    = apb_acc & I_PWRITE;
    wire       wr_ctrl   = apb_wr & (I_PADDR == `OFS_CTRL);
    wire       wr_clear  = apb_wr & (I_PADDR == `OFS_CLEAR);
    wire       wr_cmd    = apb_wr & (I_PADDR == `OFS_CMD);
    wire       nmi_fall  = nmi_s3_q & ~nmi_s2_q;
    wire       stop_evt  = wr_cmd & I_PWDATA[`CMD_STOP_BIT];
    wire       in_cycle  = state_q[1] | state_q[2] | state_q[3] | state_q[4];
    wire       own_rd    = (state_q[2] | state_q[3]) & ~cyc_write_q;
    wire       own_wr    = (state_q[2] | state_q[3]) & cyc_write_q;
    wire       dma_busy  = state_q[5] & (dma_cnt_q != 2'h0);
    // ----------------------------------------------------------------
    // apb slave: zero wait, answer prepared in setup phase
    // ----------------------------------------------------------------
    always @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            O_PREADY  <= 1'b0;
            O_PSLVERR <= 1'b0;
            O_PRDATA  <= 32'h00000000;
        end
        else
        begin
            O_PREADY  <= I_PSEL & ~I_PENABLE;
            O_PSLVERR <= I_PSEL & ~I_PENABLE & (I_PADDR != `OFS_CTRL)
                         & (I_PADDR != `OFS_STATUS) & (I_PADDR != `OFS_CLEAR)
                         & (I_PADDR != `OFS_CMD);
            O_PRDATA  <= 32'h00000000;
            if (I_PSEL & ~I_PENABLE & ~I_PWRITE)
            begin
                case (I_PADDR)
                    `OFS_CTRL:   O_PRDATA <= {26'h0, ctrl_q};
                    `OFS_STATUS: O_PRDATA <= {16'h0000, 2'h0, state_q,
                                              3'h0, cmd_pend_q, irq_q,
                                              nmi_pend_q, ~int_s2_q,
                                              ~hold_req_q};
                    default:     O_PRDATA <= 32'h00000000;
                endcase
            end
        end
    end
    // control register
    always @(posedge I_SYS_CLK)
    begin
        if (I_RST)
            ctrl_q <= `CTRL_RESET;
        else if (wr_ctrl)
            ctrl_q <= I_PWDATA[`CTRL_WIDTH-1:0];
    end
    // input synchronisers; bus request gets one stage only, trading
    // metastability margin for grant latency (requester should be synchronous)
    always @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            hold_req_q <= 1'b0;
            int_s1_q   <= 1'b1;
            int_s2_q   <= 1'b1;
            nmi_s1_q   <= 1'b1;
            nmi_s2_q   <= 1'b1;
            nmi_s3_q   <= 1'b1;
        end
        else
        begin
            hold_req_q <= ~I_BUS_REQ_N;
            int_s1_q   <= I_INT_N;
            int_s2_q   <= int_s1_q;
            nmi_s1_q   <= I_NMI_N;
            nmi_s2_q   <= nmi_s1_q;
            nmi_s3_q   <= nmi_s2_q;
        end
    end
    // sticky event flags; a new event beats a simultaneous clear
    always @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            nmi_pend_q <= 1'b0;
            irq_q      <= 1'b0;
        end
        else
        begin
            if (nmi_fall)
                nmi_pend_q <= 1'b1;
            else if (wr_clear & I_PWDATA[`CLR_NMI_BIT])
                nmi_pend_q <= 1'b0;
            if (stop_evt & ctrl_q[`CTRL_IRQEN_BIT])
                irq_q <= 1'b1;
            else if (wr_clear & I_PWDATA[`CLR_IRQ_BIT])
                irq_q <= 1'b0;
        end
    end
    // bus cycle request from software; one may wait while one runs
    always @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            cmd_pend_q  <= 1'b0;
            cmd_code_q  <= `ST_IDLE;
            cmd_write_q <= 1'b0;
        end
        else if (wr_cmd & I_PWDATA[`CMD_CYCLE_BIT] & ~cmd_pend_q)
        begin
            cmd_pend_q  <= 1'b1;
            cmd_code_q  <= I_PWDATA[`CMD_CODE_MSB:0];
            cmd_write_q <= I_PWDATA[`CMD_WRITE_BIT];
        end
        else if (tick & state_d[1] & ~state_q[1])
            cmd_pend_q  <= 1'b0;
    end
    // ----------------------------------------------------------------
    // bus clock and fast clock dividers
    // ----------------------------------------------------------------
    // fast clock toggles every 2^scale system clocks; a flop output cannot
    // follow the oscillator itself, so scale 0 gives half the system rate
    always @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            bclk_q           <= 1'b0;
            fdiv_q           <= 4'h0;
            O_BUS_CLOCK_OUT  <= 1'b0;
            O_FAST_CLOCK_OUT <= 1'b0;
        end
        else
        begin
            bclk_q          <= ~bclk_q;
            O_BUS_CLOCK_OUT <= ~bclk_q;
            if (fdiv_q >= ((4'h1 << ctrl_q[`CTRL_SCALE_MSB:`CTRL_SCALE_LSB]) - 4'h1))
            begin
                fdiv_q           <= 4'h0;
                O_FAST_CLOCK_OUT <= ~O_FAST_CLOCK_OUT;
            end
            else
                fdiv_q <= fdiv_q + 4'h1;
        end
    end
    // ----------------------------------------------------------------
    // cycle sequencer and hold arbitration
    // ----------------------------------------------------------------
    always @*
    begin
        state_d = state_q;
        case (state_q)
            S_IDLE:
            begin
                if (hold_req_q)
                    state_d = S_HOLD;
                else if (cmd_pend_q)
                    state_d = S_T1;
            end
            S_T1: state_d = S_T2;
            S_T2:
            begin
                if (~I_CONTINUOUS_WAIT_N)
                    state_d = S_T3;
                else
                    state_d = S_T4;
            end
            S_T3:
            begin
                if (I_CONTINUOUS_WAIT_N)
                    state_d = S_T4;
            end
            S_T4:
            begin
                if (committed_q)
                    state_d = S_T1;
                else if (hold_req_q)
                    state_d = S_HOLD;
                else if (cmd_pend_q)
                    state_d = S_T1;
                else
                    state_d = S_IDLE;
            end
            S_HOLD:
            begin
                if (~hold_req_q & ~dma_busy)
                    state_d = S_IDLE;
            end
            default: state_d = S_IDLE;
        endcase
    end
    // follow-on cycle is committed one state before T4; later requests wait a T4
    always @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            state_q     <= S_IDLE;
            committed_q <= 1'b0;
            cyc_code_q  <= `ST_IDLE;
            cyc_write_q <= 1'b0;
        end
        else if (tick)
        begin
            state_q <= state_d;
            if (state_d[4] & ~state_q[4])
                committed_q <= cmd_pend_q & ~hold_req_q;
            else if (state_d[1])
                committed_q <= 1'b0;
            if (state_d[1] & ~state_q[1])
            begin
                cyc_code_q  <= cmd_code_q;
                cyc_write_q <= cmd_write_q;
            end
        end
    end
    // dma strobe generation while the bus is granted
    always @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            dma_ads_q   <= 1'b1;
            dma_cnt_q   <= 2'h0;
            dma_write_q <= 1'b0;
        end
        else if (tick)
        begin
            dma_ads_q <= I_ADDR_STROBE_N;
            if (state_q[5] & dma_ads_q & ~I_ADDR_STROBE_N)
            begin
                dma_cnt_q   <= `DMA_STROBE_TICKS;
                dma_write_q <= I_TRANSFER_DIRECTION;
            end
            else if (dma_cnt_q != 2'h0)
                dma_cnt_q <= dma_cnt_q - 2'h1;
        end
    end
    // ----------------------------------------------------------------
    // pin outputs, all registered
    // ----------------------------------------------------------------
    always @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            O_ADDR_STROBE_N           <= 1'b1;
            O_ADDR_STROBE_OE_N        <= 1'b0;
            O_TRANSFER_DIRECTION      <= 1'b0;
            O_TRANSFER_DIRECTION_OE_N <= 1'b0;
            O_BUS_GRANT_ACK_N         <= 1'b1;
            O_ADDR_LATCH_EN           <= 1'b0;
            O_CYCLE_STATUS            <= `ST_IDLE;
            O_STATE_TIMING_N          <= 1'b1;
            O_READ_N                  <= 1'b1;
            O_WRITE_N                 <= 1'b1;
            O_DATA_BUFFER_ENABLE      <= 1'b0;
            O_BLIT_CYCLE_N            <= 1'b1;
        end
        else
        begin
            // strobe and direction pins are released to the outside master while granted
            O_ADDR_STROBE_N           <= ~state_q[1];
            O_ADDR_STROBE_OE_N        <= state_q[5];
            O_TRANSFER_DIRECTION      <= cyc_write_q;
            O_TRANSFER_DIRECTION_OE_N <= state_q[5];
            O_BUS_GRANT_ACK_N         <= ~state_q[5];
            O_ADDR_LATCH_EN           <= state_q[1] | state_q[5]
                                         | (state_q[4] & ~committed_q & hold_req_q);
            O_CYCLE_STATUS            <= in_cycle ? cyc_code_q : `ST_IDLE;
            O_STATE_TIMING_N          <= ~(state_q[2] | state_q[3]
                                           | dma_busy);
            O_READ_N                  <= ~(own_rd | (dma_busy & ~dma_write_q));
            O_WRITE_N                 <= ~(own_wr | (dma_busy & dma_write_q));
            O_DATA_BUFFER_ENABLE      <= state_q[2] | state_q[3] | dma_busy;
            O_BLIT_CYCLE_N            <= ~(in_cycle & (is_fetch(cyc_code_q)
                                           | (ctrl_q[`CTRL_BLIT_BIT]
                                              & (cyc_code_q == `ST_DATA_XFER))));
        end
    end
    // instruction status and system outputs
    always @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            O_USER_MODE           <= 1'b0;
            O_INTERLOCK_ACTIVE_N  <= 1'b1;
            O_INSTR_START_PULSE_N <= 1'b1;
            O_RESET_OUT_N         <= 1'b0;
            O_CMDLIST_IRQ_OUT     <= 1'b0;
        end
        else
        begin
            O_USER_MODE           <= ctrl_q[`CTRL_USER_BIT];
            O_INTERLOCK_ACTIVE_N  <= ~ctrl_q[`CTRL_LOCK_BIT];
            O_INSTR_START_PULSE_N <= ~(wr_cmd & I_PWDATA[`CMD_START_BIT]);
            O_RESET_OUT_N         <= I_RESET_IN_N;
            O_CMDLIST_IRQ_OUT     <= irq_q;
        end
    end
endmodule // bus_signal_if

// *** design/bus_signal_if_defines.vh ***
// constants for the external bus signal interface block
`ifndef BUS_SIGNAL_IF_DEFINES_VH
`define BUS_SIGNAL_IF_DEFINES_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_CLEAR       8'h08
`define OFS_CMD         8'h0C
// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTRL_USER_BIT   0
`define CTRL_SCALE_LSB  1
`define CTRL_SCALE_MSB  2
`define CTRL_IRQEN_BIT  3
`define CTRL_BLIT_BIT   4
`define CTRL_LOCK_BIT   5
`define CTRL_WIDTH      6
`define CTRL_RESET      6'h00
// ----------------------------------------------------------------
// command register fields
// ----------------------------------------------------------------
`define CMD_CODE_MSB    3
`define CMD_WRITE_BIT   4
`define CMD_START_BIT   5
`define CMD_STOP_BIT    6
`define CMD_CYCLE_BIT   7
// ----------------------------------------------------------------
// clear register fields (write one to clear)
// ----------------------------------------------------------------
`define CLR_NMI_BIT     0
`define CLR_IRQ_BIT     1
// ----------------------------------------------------------------
// cycle status codes
// ----------------------------------------------------------------
`define ST_IDLE         4'h0
`define ST_WAIT_INSTR   4'h1
`define ST_DSP_XFER     4'h2
`define ST_SLAVE_WAIT   4'h3
`define ST_INTA_MASTER  4'h4
`define ST_INTA_CASC    4'h5
`define ST_EOI_MASTER   4'h6
`define ST_EOI_CASC     4'h7
`define ST_FETCH_SEQ    4'h8
`define ST_FETCH_NSEQ   4'h9
`define ST_DATA_XFER    4'hA
`define ST_RMW_READ     4'hB
`define ST_EA_READ      4'hC
`define ST_SLV_OPERAND  4'hD
`define ST_SLV_STATUS   4'hE
`define ST_SLV_ID       4'hF
// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define DMA_STROBE_TICKS 2'h2
`endif
